// [rtl/pbp_top.sv]
// Purpose: Open-drain 16-port expander core with two phase banks and PWM
// Assumes: Serial host front end delivers decoded register reads and writes
// Notes:   Read data returns one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "pbp_defs.svh"

// Functional notes
// [R1] Setup bit 6 reads synced phase pin
// [R2] Bit 7 change flag; irq low when set
// [R3] Enabled: phase is swap XOR phase pin
// [R4] Disabled: phase 0 bank alone drives
// [R5] Phase bit 1 releases, 0 drives low
// [R6] Direction 1 input, 0 output; readable
// [R7] Inputs read at 0x00 and 0x01
// [R8] Phase registers read stored value
// [R9] Seventeenth output uses two setup bits
// [R10] 32kHz tick; stopped when PWM off
// [R11] 240 steps, 15 slots of 16
// [R12] Master gates 1 to 15 slots
// [R13] Individual nibbles or one global nibble
// [R14] Static and PWM outputs mix freely
// [R15] Host may fill phase 1 with ones
// [R16] Master zero disables PWM, all static
// [R17] Full scale ignores master, static
// [R18] Irq disabled: aux pin follows phase bits
// [R19] Phase pin synchronised before use
// [R20] Gated-on steps apply phase bit, else release
module pbp_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [15:0] port_pins_in,
  output logic      [15:0] port_pins_out,
  output logic      [15:0] port_pins_oe,
  input  wire logic        phase_pin,
  output logic             irq_or_aux_output_pin_out,
  output logic             irq_or_aux_output_pin_oe
);

  localparam int unsigned OSC_DIV = `PBP_CLK_HZ / `PBP_OSC_HZ;
  localparam logic [8:0]  OSC_LAST = 9'(OSC_DIV - 1);
  localparam logic [7:0]  STEP_LAST = 8'(`PBP_PWM_STEPS - 1);

  pbp_pkg::pbp_state_s r;
  pbp_pkg::pbp_state_s next_r;

  logic [16:0] sync_out;
  logic [15:0] pin_sample_bit;
  logic        phase_pin_s;

  // Gate for one output: 1 means the phase bit is applied this step
  function automatic logic pwm_gate(
    input logic [3:0] master,
    input logic [3:0] level,
    input logic [7:0] step
  );
    logic [3:0] slot;
    logic [3:0] cyc;
    slot = step[7:4];
    cyc  = step[3:0];
    if (level == `PBP_FULL_SCALE) begin
      pwm_gate = 1'b1; // R17
    end else if (master == 4'h0) begin
      pwm_gate = 1'b1; // R16
    end else begin
      pwm_gate = (slot < master) && (cyc <= level); // R12
    end
  endfunction : pwm_gate

  pbp_sync3 u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({phase_pin, port_pins_in}),
    .stable   (sync_out)
  );

  assign pin_sample_bit = sync_out[15:0];
  assign phase_pin_s    = sync_out[16]; // R19

  always_comb begin
    logic       phase_sel;
    logic       lvl_bit;
    logic [3:0] lvl;
    logic [15:0] chg;
    logic       clr_chg;
    phase_sel = 1'b0;
    lvl_bit   = 1'b0;
    lvl       = 4'h0;
    chg       = 16'h0000;
    clr_chg   = 1'b0;
    next_r    = r;
    next_r.rvalid = reg_rd;

    // Active phase bank selection
    if (r.setup[`PBP_CFG_PHASE_EN]) begin
      phase_sel = r.setup[`PBP_CFG_SWAP] ^ phase_pin_s; // R3
    end else begin
      phase_sel = 1'b0; // R4
    end

    // Oscillator tick and PWM step counter, held in reset while PWM is off
    if (r.master[7:4] == 4'h0) begin
      next_r.osc_cnt = 9'h000; // R10
      next_r.step    = 8'h00; // R16
    end else if (r.osc_cnt == OSC_LAST) begin
      next_r.osc_cnt = 9'h000;
      if (r.step == STEP_LAST) begin
        next_r.step = 8'h00; // R11
      end else begin
        next_r.step = r.step + 8'h01;
      end
    end else begin
      next_r.osc_cnt = r.osc_cnt + 9'h001; // R10
    end

    // Port outputs: each pin has its own level unless the global bit is set, so static and PWM mix
    for (int k = 0; k < 16; k++) begin
      lvl_bit = phase_sel ? r.ph1[k] : r.ph0[k]; // R3
      if (r.setup[`PBP_CFG_GLOBAL]) begin
        lvl = r.master[3:0]; // R13
      end else begin
        lvl = r.inten[4*k +: 4]; // R13
      end
      // Input direction releases the pin regardless of the bank
      next_r.drv_low[k] = !r.dir[k] && !lvl_bit && pwm_gate(r.master[7:4], lvl, r.step); // R5 R6 R14 R20
    end

    // Input change detection on pins configured as inputs
    chg = (pin_sample_bit ^ r.snap) & r.dir;
    if (reg_rd && ((reg_addr == `PBP_ADDR_SAMPLE_LO) || (reg_addr == `PBP_ADDR_SAMPLE_HI))) begin
      clr_chg     = 1'b1;
      next_r.snap = pin_sample_bit;
    end
    // A change seen in the clearing cycle keeps the flag set
    if (chg != 16'h0000) begin
      next_r.chg_flag = 1'b1; // R2
    end else if (clr_chg) begin
      next_r.chg_flag = 1'b0;
    end

    // Seventeenth output or shared interrupt
    if (r.setup[`PBP_CFG_IRQ_EN]) begin
      next_r.aux_low = r.chg_flag; // R2
    end else begin
      lvl_bit = phase_sel ? r.setup[`PBP_CFG_AUX_PH1] : r.setup[`PBP_CFG_AUX_PH0]; // R9 R18
      next_r.aux_low = !lvl_bit && pwm_gate(r.master[7:4], r.master[3:0], r.step); // R9
    end

    // Register writes; read-only addresses ignore writes
    if (reg_wr) begin
      if (reg_addr == `PBP_ADDR_PH0_LO) begin
        next_r.ph0[7:0] = reg_wdata;
      end else if (reg_addr == `PBP_ADDR_PH0_HI) begin
        next_r.ph0[15:8] = reg_wdata;
      end else if (reg_addr == `PBP_ADDR_PH1_LO) begin
        next_r.ph1[7:0] = reg_wdata; // R15
      end else if (reg_addr == `PBP_ADDR_PH1_HI) begin
        next_r.ph1[15:8] = reg_wdata; // R15
      end else if (reg_addr == `PBP_ADDR_DIR_LO) begin
        next_r.dir[7:0] = reg_wdata; // R6
      end else if (reg_addr == `PBP_ADDR_DIR_HI) begin
        next_r.dir[15:8] = reg_wdata; // R6
      end else if (reg_addr == `PBP_ADDR_MASTER) begin
        next_r.master = reg_wdata;
      end else if (reg_addr == `PBP_ADDR_SETUP) begin
        // Status bits 7 and 6 are not writable
        next_r.setup = reg_wdata[5:0];
      end else if ((reg_addr >= `PBP_ADDR_INTEN_BASE) && (reg_addr <= `PBP_ADDR_INTEN_LAST)) begin
        next_r.inten[8*reg_addr[2:0] +: 8] = reg_wdata; // R13
      end
    end

    // Register reads, returned from a flop one cycle later
    if (reg_rd) begin
      if (reg_addr == `PBP_ADDR_SAMPLE_LO) begin
        next_r.rdata = pin_sample_bit[7:0]; // R7
      end else if (reg_addr == `PBP_ADDR_SAMPLE_HI) begin
        next_r.rdata = pin_sample_bit[15:8]; // R7
      end else if (reg_addr == `PBP_ADDR_PH0_LO) begin
        next_r.rdata = r.ph0[7:0]; // R8
      end else if (reg_addr == `PBP_ADDR_PH0_HI) begin
        next_r.rdata = r.ph0[15:8]; // R8
      end else if (reg_addr == `PBP_ADDR_PH1_LO) begin
        next_r.rdata = r.ph1[7:0]; // R8
      end else if (reg_addr == `PBP_ADDR_PH1_HI) begin
        next_r.rdata = r.ph1[15:8]; // R8
      end else if (reg_addr == `PBP_ADDR_DIR_LO) begin
        next_r.rdata = r.dir[7:0]; // R6
      end else if (reg_addr == `PBP_ADDR_DIR_HI) begin
        next_r.rdata = r.dir[15:8]; // R6
      end else if (reg_addr == `PBP_ADDR_MASTER) begin
        next_r.rdata = r.master;
      end else if (reg_addr == `PBP_ADDR_SETUP) begin
        next_r.rdata = {r.chg_flag, phase_pin_s, r.setup}; // R1 R2
      end else if ((reg_addr >= `PBP_ADDR_INTEN_BASE) && (reg_addr <= `PBP_ADDR_INTEN_LAST)) begin
        next_r.rdata = r.inten[8*reg_addr[2:0] +: 8];
      end else begin
        next_r.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r          <= '0;
      r.dir      <= `PBP_RST_DIR;
      r.ph0      <= `PBP_RST_PHASE;
      r.ph1      <= `PBP_RST_PHASE;
      r.setup    <= `PBP_RST_SETUP;
      r.master   <= `PBP_RST_MASTER;
      r.inten    <= `PBP_RST_INTEN;
    end else begin
      r <= next_r;
    end
  end

  // Open drain: the pins only ever sink, so the data side is a constant low
  assign port_pins_out             = 16'h0000;
  assign port_pins_oe              = r.drv_low;
  assign irq_or_aux_output_pin_out = 1'b0;
  assign irq_or_aux_output_pin_oe  = r.aux_low;
  assign reg_rdata                 = r.rdata;
  assign reg_rvalid                = r.rvalid;

endmodule : pbp_top

`default_nettype wire

// [rtl/pbp_defs.svh]
// Purpose: Constants for the port blink/PWM control block
// Assumes: 8-bit register addresses, 10 MHz system clock
// Notes:   Offsets are the register addresses as seen by the host
`ifndef PBP_DEFS_SVH
`define PBP_DEFS_SVH

// Register addresses
`define PBP_ADDR_SAMPLE_LO   8'h00
`define PBP_ADDR_SAMPLE_HI   8'h01
`define PBP_ADDR_PH0_LO      8'h02
`define PBP_ADDR_PH0_HI      8'h03
`define PBP_ADDR_DIR_LO      8'h06
`define PBP_ADDR_DIR_HI      8'h07
`define PBP_ADDR_PH1_LO      8'h0a
`define PBP_ADDR_PH1_HI      8'h0b
`define PBP_ADDR_MASTER      8'h0e
`define PBP_ADDR_SETUP       8'h0f
`define PBP_ADDR_INTEN_BASE  8'h10
`define PBP_ADDR_INTEN_LAST  8'h17

// Setup register fields
`define PBP_CFG_PHASE_EN     0
`define PBP_CFG_SWAP         1
`define PBP_CFG_GLOBAL       2
`define PBP_CFG_IRQ_EN       3
`define PBP_CFG_AUX_PH0      4
`define PBP_CFG_AUX_PH1      5
`define PBP_CFG_PIN_STAT     6
`define PBP_CFG_CHG_STAT     7

// Reset values
`define PBP_RST_DIR          16'hffff
`define PBP_RST_PHASE        16'hffff
`define PBP_RST_MASTER       8'h00
`define PBP_RST_SETUP        6'h00
`define PBP_RST_INTEN        64'h0000_0000_0000_0000

// Timing
`define PBP_CLK_HZ           10000000
`define PBP_OSC_HZ           32000
`define PBP_PWM_STEPS        240
`define PBP_SLOT_CYCLES      16
`define PBP_FULL_SCALE       4'hf

`endif

// [rtl/pbp_pkg.sv]
// Purpose: Types for the port blink/PWM control block
// Assumes: Sixteen ports plus one phase pin sampled together
// Notes:   Constants live in pbp_defs.svh
package pbp_pkg;

  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] s3;
    logic [16:0] stable;
  } pbp_sync_s;

  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] ph0;
    logic [15:0] ph1;
    logic [5:0]  setup;
    logic [7:0]  master;
    logic [63:0] inten;
    logic [15:0] snap;
    logic        chg_flag;
    logic [8:0]  osc_cnt;
    logic [7:0]  step;
    logic [15:0] drv_low;
    logic        aux_low;
    logic [7:0]  rdata;
    logic        rvalid;
  } pbp_state_s;

endpackage : pbp_pkg

// [rtl/pbp_sync3.sv]
// Purpose: Three-stage synchroniser for the port pins and the phase pin
// Assumes: Inputs are asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pbp_sync3 (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [16:0] async_in,
  output logic      [16:0] stable
);

  pbp_pkg::pbp_sync_s r;
  pbp_pkg::pbp_sync_s next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < 17; i++) begin
      // Two agreeing stages filter a single-cycle metastable settle
      if (r.s2[i] == r.s3[i]) begin
        next_r.stable[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign stable = r.stable;

endmodule : pbp_sync3

`default_nettype wire

// [verification/pbp_host_model.sv]
// Purpose: Host model issuing register reads and writes
// Assumes: Strobes change at falling edges only
// Notes:   Released address and data show the inverse value
`timescale 1ns/1ps
`default_nettype none
module pbp_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  // Optional write, then a read of the same place in the next cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic v);
    if (w) begin
      @(negedge clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    end
    @(negedge clk);
    {reg_addr, reg_wr, reg_rd} = {a, 1'b0, 1'b1};
    @(negedge clk);
    {reg_addr, reg_wdata, reg_rd} = {~a, ~d, 1'b0};
    {q, v} = {reg_rdata, reg_rvalid};
  endtask : xfer
endmodule : pbp_host_model
`default_nettype wire

// [verification/pbp_top_properties.sv]
// Purpose: Port checks for pbp_top
// Assumes: Shadows of writable registers rebuilt from host writes
// Notes:   Pin synchroniser lag of up to six clocks allowed
`timescale 1ns/1ps
`default_nettype none
module pbp_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [15:0] port_pins_in,
  input wire logic [15:0] port_pins_out,
  input wire logic [15:0] port_pins_oe,
  input wire logic        phase_pin,
  input wire logic        irq_or_aux_output_pin_out,
  input wire logic        irq_or_aux_output_pin_oe
);
  logic [15:0] dir, ph0, ph1;
  logic [7:0]  cfg, mst;
  wire         st = mst[7:4] == 4'h0;
  wire  [63:0] sh = {dir, ph0, ph1, cfg, mst};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {dir, ph0, ph1, cfg, mst} <= {48'hffff_ffff_ffff, 16'h0000};
    end else if (reg_wr) begin
      case (reg_addr)
        8'h02: ph0[7:0] <= reg_wdata;
        8'h03: ph0[15:8] <= reg_wdata;
        8'h06: dir[7:0] <= reg_wdata;
        8'h07: dir[15:8] <= reg_wdata;
        8'h0a: ph1[7:0] <= reg_wdata;
        8'h0b: ph1[15:8] <= reg_wdata;
        8'h0e: mst <= reg_wdata;
        8'h0f: cfg <= reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid after read");
  property p_od; port_pins_out == 16'h0000 && !irq_or_aux_output_pin_out; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_smp; ($stable(port_pins_in))[*6] ##0 reg_rd && reg_addr == 8'h00
    |=> reg_rdata == $past(port_pins_in[7:0]); endproperty
  a_smp: assert property (p_smp) else $error("input sample wrong");
  property p_ps; ($stable(phase_pin))[*6] ##0 reg_rd && reg_addr == 8'h0f |=> reg_rdata[6] == $past(phase_pin);
  endproperty
  a_ps: assert property (p_ps) else $error("phase pin status wrong");
  property p_rb; reg_wr && reg_addr == 8'h06 ##1 reg_rd && !reg_wr && reg_addr == 8'h06
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_rb: assert property (p_rb) else $error("direction readback wrong");
  property p_s0; (st && !cfg[0] && $stable(sh))[*2] |-> port_pins_oe == (~dir & ~ph0); endproperty
  a_s0: assert property (p_s0) else $error("static output wrong");
  property p_ph; (st && cfg[0] && $stable(sh) && $stable(phase_pin))[*7]
    |-> port_pins_oe == (~dir & ~(cfg[1] ^ phase_pin ? ph1 : ph0)); endproperty
  a_ph: assert property (p_ph) else $error("phase bank choice wrong");
  property p_ax; (st && !cfg[0] && !cfg[3] && $stable(sh))[*2] |-> irq_or_aux_output_pin_oe == !cfg[4]; endproperty
  a_ax: assert property (p_ax) else $error("aux output wrong");
  c_pwm: cover property (!st ##1 $changed(port_pins_oe));
  c_flag: cover property (reg_rd && reg_addr == 8'h0f ##1 reg_rdata[7]);
  c_phase: cover property (cfg[0] && $rose(phase_pin));
endmodule : pbp_props
bind pbp_top pbp_props u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .port_pins_in(port_pins_in), .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
  .phase_pin(phase_pin), .irq_or_aux_output_pin_out(irq_or_aux_output_pin_out),
  .irq_or_aux_output_pin_oe(irq_or_aux_output_pin_oe));
`default_nettype wire

// [verification/pbp_top_test.sv]
// Purpose: Self-checking bench for pbp_top
// Assumes: Host model owns the register strobes
// Notes:   One whole PWM period is counted, so the run is long
`timescale 1ns/1ps
`default_nettype none
module pbp_top_test;
  localparam int TICK = 312;
  localparam int PERIOD = 240 * TICK;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        phase_pin = 1'b0;
  logic [15:0] port_pins_in = 16'h0000;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
  logic        reg_wr, reg_rd, reg_rvalid, aux_oe;
  logic [15:0] pins_oe, v, p0, p1;
  logic [31:0] seed = 32'h0001_5f55;
  logic [31:0] c0, c1, c2, c3;
  logic [3:0]  m, l;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [7:0]  rregs [6] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h0a, 8'h0b};
  pbp_top DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_pins_in(port_pins_in),
    .port_pins_out(), .port_pins_oe(pins_oe), .phase_pin(phase_pin),
    .irq_or_aux_output_pin_out(), .irq_or_aux_output_pin_oe(aux_oe));
  pbp_host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nxt
  function automatic logic [31:0] exp_on(input logic [3:0] ms, input logic [3:0] lv);
    return 32'(TICK) * 32'(ms) * (32'(lv) + 32'd1);
  endfunction : exp_on
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_out(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_out
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic rv;
    h.xfer(w, a, d, q, rv);
    chk_reg("rvalid", 8'h01, {7'h00, rv});
  endtask : acc
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, d[7:0]);
    acc(1'b1, a + 8'h01, d[15:8]);
  endtask : wr16
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // Ceiling covers one PWM period plus the short tests
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    foreach (rregs[i]) begin
      acc(1'b0, rregs[i], 8'h00);
      chk_reg("reset value", 8'hff, q);
      seed = nxt(seed);
      acc(1'b1, rregs[i], seed[7:0]);
      chk_reg("readback", seed[7:0], q);
    end
    wr16(8'h06, 16'hffff);
    acc(1'b1, 8'h0f, 8'h08);
    v = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      v = (i == 0) ? 16'hffff : v ^ (seed[15:0] | 16'h0001);
      @(negedge clk) port_pins_in = v;
      repeat (6) @(negedge clk);
      acc(1'b0, 8'h0f, 8'h00);
      chk_reg("flag set", 8'h88, q);
      chk_out("irq low", 32'h1, {31'h0, aux_oe});
      acc(1'b1, 8'h00, 8'h5a);
      chk_reg("inputs low", v[7:0], q);
      acc(1'b0, 8'h01, 8'h00);
      chk_reg("inputs high", v[15:8], q);
      acc(1'b0, 8'h0f, 8'h00);
      chk_reg("flag clear", 8'h08, q);
      chk_out("irq high", 32'h0, {31'h0, aux_oe});
    end
    wr16(8'h06, 16'h0000);
    seed = nxt(seed);
    {p1, p0} = seed;
    wr16(8'h02, p0);
    wr16(8'h0a, p1);
    acc(1'b1, 8'h0f, 8'h02);
    @(negedge clk) phase_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_out("static oe", {16'h0, ~p0}, {16'h0, pins_oe});
    chk_out("aux static", 32'h1, {31'h0, aux_oe});
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h0f, {6'h04, i[1], 1'b1});
      @(negedge clk) phase_pin = i[0];
      repeat (8) @(negedge clk);
      chk_out("phase oe", {16'h0, ~((i[0] ^ i[1]) ? p1 : p0)}, {16'h0, pins_oe});
      chk_out("aux phase", {31'h0, i[0] ^ i[1]}, {31'h0, aux_oe});
      acc(1'b0, 8'h0f, 8'h00);
      chk_reg("pin status", {1'b0, i[0], 4'h4, i[1], 1'b1}, q);
    end
    wr16(8'h0a, 16'hffff);
    acc(1'b1, 8'h0f, 8'h01);
    @(negedge clk) phase_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_out("blanked", 32'h0, {16'h0, pins_oe});
    wr16(8'h02, 16'h0000);
    acc(1'b1, 8'h0f, 8'h00);
    seed = nxt(seed);
    m = seed[3:0] % 4'hf + 4'h1;
    l = seed[7:4] % 4'hf;
    acc(1'b1, 8'h10, {4'hf, l});
    acc(1'b1, 8'h0e, {m, 4'h0});
    repeat (4) @(negedge clk);
    {c0, c1, c2, c3} = 128'h0;
    repeat (PERIOD) begin
      @(negedge clk);
      c0 += {31'h0, pins_oe[0]};
      c1 += {31'h0, pins_oe[1]};
      c2 += {31'h0, pins_oe[2]};
      c3 += {31'h0, aux_oe};
    end
    chk_out("pwm level", exp_on(m, l), c0);
    chk_out("full scale", 32'(PERIOD), c1);
    chk_out("pwm lowest", exp_on(m, 4'h0), c2);
    chk_out("aux pwm", exp_on(m, 4'h0), c3);
    // Global full scale must make every port static, even those set to zero
    acc(1'b1, 8'h0f, 8'h04);
    acc(1'b1, 8'h0e, {m, 4'hf});
    repeat (4) @(negedge clk);
    {c2, c3} = 64'h0;
    repeat (16 * TICK) begin
      @(negedge clk);
      c2 += {31'h0, pins_oe[2]};
      c3 += {31'h0, aux_oe};
    end
    chk_out("global full", 32'(16 * TICK), c2);
    chk_out("aux global", 32'(16 * TICK), c3);
    conclude();
  end
endmodule : pbp_top_test
`default_nettype wire
